/* File: rcw_event_src.sv */
// external event source for the counter pin and oscillator input
`timescale 1ns/1ns
`default_nettype none
module rcw_event_src (
  input wire logic clock,
  output logic oscPin,
  output logic countPin
);
  logic [1:0] divQ = 2'h0;
  initial begin
    oscPin = 1'b0;
    countPin = 1'b0;
  end
  // free-running oscillator, four clocks a period
  always @(posedge clock) begin
    divQ <= divQ + 2'h1;
    oscPin <= divQ[1];
  end
  // each level held three oscillator periods
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (12) @(posedge clock);
      countPin <= 1'b1;
      repeat (12) @(posedge clock);
      countPin <= 1'b0;
    end
  endtask
endmodule // rcw_event_src
`default_nettype wire

/* File: rcw_pkg.sv */
// constants for the real-time counter, watchdog and shared prescaler
`default_nettype none
package rcw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_COUNTER = 8'h04;
  localparam logic [7:0] OFS_TIMER1_CTRL_B = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_ZERO_CHECK = 8'h1c;
  localparam logic [7:0] OFS_WATCHDOG = 8'h20;
  // option register fields
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_SOURCE_BIT = 5;
  localparam int OPT_ROLL_IE_BIT = 7;
  localparam logic [7:0] OPTION_RESET = 8'h0f;
  // timer1 control b and status fields
  localparam int T1CB_PENDING_BIT = 7;
  localparam int STAT_ROLLOVER_BIT = 0;
  localparam int STAT_WATCHDOG_BIT = 1;
  localparam int CMD_WD_CLEAR_BIT = 0;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_OSC_PERIOD_NS = 62500;
  localparam int WD_TICK_CYCLES = WD_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int INSTR_CYCLES = 1;
endpackage
`default_nettype wire

/* File: rcw_timer.sv */
// real-time counter and watchdog sharing one prescaler, apb register slave
//
// What this block does
// - 8-bit counter advances on instruction cycles or external pin edges.
// - 8-bit prescaler in front extends counter range to 16 bits.
// - source bit zero: count instruction cycles, or prescaler outputs.
// - source bit one: sample pin at oscillator rising edges, count edges.
// - edge bit one counts falling edges, zero counts rising edges.
// - counter wrap FFh to 00h sets pending flag, requests interrupt.
// - software counter write clears prescaler when it serves the counter.
// - zero-check read access holds the counter for that cycle.
// - watchdog ticks from its own nominal 16 kHz timebase.
// - watchdog counts 00h to FFh; overflow resets device if fused.
// - assign bit one: prescaler is watchdog postscaler, rate bits ratio.
// - assign bit zero: prescaler divides counter source; never shared.
// - prescaler count has no software access.
// - rollover interrupt gated by enable bit in option register.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rcw_timer #(
  parameter int WD_TICK_CYCLES = rcw_pkg::WD_TICK_CYCLES,
  parameter int INSTR_CYCLES = rcw_pkg::INSTR_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic counterPin,
  input wire logic oscillatorInputPin,
  input wire logic watchdogEnableFuse,
  output logic watchdogResetReq,
  output logic irq
);

  if (WD_TICK_CYCLES < 4 || WD_TICK_CYCLES > 65535) begin : gBadTick
    $error("WD_TICK_CYCLES out of range");
  end
  if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255) begin : gBadInstr
    $error("INSTR_CYCLES out of range");
  end

  // all-ones low bits mark the prescaler output for a given ratio
  function automatic logic [7:0] ratioMask(input logic [2:0] rate,
                                           input logic toWatchdog);
    logic [8:0] m;
    m = 9'h0;
    m = (9'h2 << rate) - 9'h1;
    if (toWatchdog) begin
      m = {1'b0, m[8:1]};
    end
    return m[7:0];
  endfunction

  logic [7:0] optionQ, optionD;
  logic [7:0] counterQ, counterD;
  logic [7:0] prescaleQ, prescaleD;
  logic [7:0] watchdogQ, watchdogD;
  logic [15:0] wdDivQ, wdDivD;
  logic [7:0] instrDivQ, instrDivD;
  logic [1:0] statusQ, statusD;
  logic [1:0] irqEnableQ, irqEnableD;
  logic oscPrevQ, oscPrevD;
  logic pinSampleQ, pinSampleD;
  logic fuseQ, fuseD;
  logic resetReqQ, resetReqD;
  logic [31:0] rdataQ, rdataD;
  logic errQ, errD;

  logic setup, wrAccess, rdAccess, mapped;
  logic assignWd, instrTick, wdTick, extEdge, oscRise, pinNow;
  logic srcTick, psFull, cntAdvance, cntWrite, zeroCheck;
  logic rollover, wdOverflow, wdExpire, wdClear;
  logic [7:0] mask;

  assign pready = 1'b1;
  assign prdata = rdataQ;
  assign pslverr = errQ;
  assign watchdogResetReq = resetReqQ;
  assign irq = (statusQ[rcw_pkg::STAT_ROLLOVER_BIT]
                & irqEnableQ[rcw_pkg::STAT_ROLLOVER_BIT]
                & optionQ[rcw_pkg::OPT_ROLL_IE_BIT])
             | (statusQ[rcw_pkg::STAT_WATCHDOG_BIT]
                & irqEnableQ[rcw_pkg::STAT_WATCHDOG_BIT]);

  always_comb begin
    setup = psel & ~penable;
    wrAccess = psel & penable & pwrite;
    rdAccess = psel & penable & ~pwrite;
    mapped = (paddr <= rcw_pkg::OFS_WATCHDOG) && (paddr[1:0] == 2'h0);
    assignWd = optionQ[rcw_pkg::OPT_ASSIGN_BIT];
    mask = ratioMask(optionQ[rcw_pkg::OPT_RATE_LSB +: 3], assignWd);
    psFull = (prescaleQ & mask) == mask;
    instrTick = (instrDivQ == 8'(INSTR_CYCLES - 1));
    wdTick = (wdDivQ == 16'(WD_TICK_CYCLES - 1));
    oscRise = oscillatorInputPin & ~oscPrevQ;
    pinNow = oscRise ? counterPin : pinSampleQ;
    extEdge = oscRise && (optionQ[rcw_pkg::OPT_EDGE_BIT]
              ? (pinSampleQ & ~counterPin)
              : (~pinSampleQ & counterPin));
    srcTick = optionQ[rcw_pkg::OPT_SOURCE_BIT] ? extEdge : instrTick;
    cntWrite = wrAccess && paddr == rcw_pkg::OFS_COUNTER;
    zeroCheck = rdAccess && paddr == rcw_pkg::OFS_ZERO_CHECK;
    wdClear = wrAccess && paddr == rcw_pkg::OFS_COMMAND
              && pwdata[rcw_pkg::CMD_WD_CLEAR_BIT];
    // prescaler only between source and counter when not assigned away
    cntAdvance = srcTick && (assignWd || psFull) && !zeroCheck;
    rollover = cntAdvance && !cntWrite && counterQ == 8'hff;
    wdOverflow = wdTick && watchdogQ == 8'hff && !wdClear;
    wdExpire = wdOverflow && (!assignWd || psFull);
  end

  always_comb begin
    optionD = optionQ;
    counterD = counterQ;
    prescaleD = prescaleQ;
    watchdogD = watchdogQ;
    statusD = statusQ;
    irqEnableD = irqEnableQ;
    rdataD = rdataQ;
    errD = errQ;
    oscPrevD = oscillatorInputPin;
    pinSampleD = pinNow;
    fuseD = watchdogEnableFuse;
    resetReqD = wdExpire && fuseQ;
    instrDivD = instrTick ? 8'h0 : instrDivQ + 8'h1;
    wdDivD = wdTick ? 16'h0 : wdDivQ + 16'h1;

    // counter and its prescaler
    if (!assignWd && srcTick && !zeroCheck) begin
      prescaleD = prescaleQ + 8'h1;
    end
    if (cntAdvance) begin
      counterD = counterQ + 8'h1;
    end
    // watchdog and postscaler
    if (wdTick) begin
      watchdogD = watchdogQ + 8'h1;
    end
    if (assignWd && wdOverflow) begin
      prescaleD = prescaleQ + 8'h1;
    end
    if (wdClear) begin
      watchdogD = 8'h0;
      wdDivD = 16'h0;
      if (assignWd) begin
        prescaleD = 8'h0;
      end
    end

    // register writes
    if (wrAccess) begin
      unique case (paddr)
        rcw_pkg::OFS_OPTION: optionD = pwdata[7:0];
        rcw_pkg::OFS_COUNTER: begin
          counterD = pwdata[7:0];
          if (!assignWd) begin
            prescaleD = 8'h0;
          end
        end
        rcw_pkg::OFS_TIMER1_CTRL_B: begin
          if (!pwdata[rcw_pkg::T1CB_PENDING_BIT]) begin
            statusD[rcw_pkg::STAT_ROLLOVER_BIT] = 1'b0;
          end
        end
        rcw_pkg::OFS_IRQ_CLEAR: statusD = statusQ & ~pwdata[1:0];
        rcw_pkg::OFS_IRQ_ENABLE: irqEnableD = pwdata[1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    if (rollover) begin
      statusD[rcw_pkg::STAT_ROLLOVER_BIT] = 1'b1;
    end
    if (wdExpire && fuseQ) begin
      statusD[rcw_pkg::STAT_WATCHDOG_BIT] = 1'b1;
    end

    // read data captured in the setup cycle; prescaler never visible
    if (setup) begin
      errD = !mapped;
      unique case (paddr)
        rcw_pkg::OFS_OPTION: rdataD = {24'h0, optionQ};
        rcw_pkg::OFS_COUNTER: rdataD = {24'h0, counterQ};
        rcw_pkg::OFS_ZERO_CHECK: rdataD = {24'h0, counterQ};
        rcw_pkg::OFS_TIMER1_CTRL_B:
          rdataD = {24'h0, statusQ[rcw_pkg::STAT_ROLLOVER_BIT], 7'h0};
        rcw_pkg::OFS_IRQ_STATUS: rdataD = {30'h0, statusQ};
        rcw_pkg::OFS_IRQ_ENABLE: rdataD = {30'h0, irqEnableQ};
        rcw_pkg::OFS_WATCHDOG: rdataD = {24'h0, watchdogQ};
        default: rdataD = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      optionQ <= rcw_pkg::OPTION_RESET;
      counterQ <= 8'h0;
      prescaleQ <= 8'h0;
      watchdogQ <= 8'h0;
      wdDivQ <= 16'h0;
      instrDivQ <= 8'h0;
      statusQ <= 2'h0;
      irqEnableQ <= rcw_pkg::IRQ_ENABLE_RESET;
      oscPrevQ <= 1'b0;
      pinSampleQ <= 1'b0;
      fuseQ <= 1'b0;
      resetReqQ <= 1'b0;
      rdataQ <= 32'h0;
      errQ <= 1'b0;
    end else begin
      optionQ <= optionD;
      counterQ <= counterD;
      prescaleQ <= prescaleD;
      watchdogQ <= watchdogD;
      wdDivQ <= wdDivD;
      instrDivQ <= instrDivD;
      statusQ <= statusD;
      irqEnableQ <= irqEnableD;
      oscPrevQ <= oscPrevD;
      pinSampleQ <= pinSampleD;
      fuseQ <= fuseD;
      resetReqQ <= resetReqD;
      rdataQ <= rdataD;
      errQ <= errD;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence counterStep;
    cntAdvance && !cntWrite;
  endsequence

  sequence extFallSeen;
    oscRise && optionQ[rcw_pkg::OPT_SOURCE_BIT]
      && optionQ[rcw_pkg::OPT_EDGE_BIT] && pinSampleQ && !counterPin;
  endsequence

  sequence wdLastTick;
    wdTick && watchdogQ == 8'hff && !wdClear && !wrAccess;
  endsequence

  sequence extRiseSeen;
    oscRise && optionQ[rcw_pkg::OPT_SOURCE_BIT]
      && !optionQ[rcw_pkg::OPT_EDGE_BIT] && !pinSampleQ && counterPin;
  endsequence

  count_step_a: assert property (counterStep |=>
    counterQ == $past(counterQ) + 8'h1)
    else $error("counter did not advance by one");

  direct_tick_a: assert property (assignWd && srcTick && !zeroCheck
    && !wrAccess |=> counterQ == $past(counterQ) + 8'h1)
    else $error("counter missed an undivided source tick");

  fall_edge_a: assert property (extFallSeen ##0 (assignWd && !zeroCheck
    && !wrAccess) |=> counterQ == $past(counterQ) + 8'h1)
    else $error("falling pin edge not counted");

  roll_flag_a: assert property (rollover |=>
    statusQ[rcw_pkg::STAT_ROLLOVER_BIT] && counterQ == 8'h0)
    else $error("rollover did not set pending flag");

  roll_gate_a: assert property (!optionQ[rcw_pkg::OPT_ROLL_IE_BIT]
    && !statusQ[rcw_pkg::STAT_WATCHDOG_BIT] |-> !irq)
    else $error("interrupt raised while rollover enable is off");

  pre_clear_a: assert property (cntWrite && !assignWd |=>
    prescaleQ == 8'h0 && counterQ == $past(pwdata[7:0]))
    else $error("counter write did not clear prescaler");

  zero_hold_a: assert property (zeroCheck && !wdTick |=>
    counterQ == $past(counterQ) && $stable(prescaleQ))
    else $error("counter moved during zero-check read");

  wd_tick_a: assert property (wdTick |=> !wdTick [*3])
    else $error("watchdog timebase ticks too fast");

  wd_expire_a: assert property (wdLastTick ##0 (fuseQ && assignWd
    && optionQ[2:0] == 3'h0) |=> watchdogResetReq ##1 !watchdogResetReq)
    else $error("postscaler 1:1 did not expire watchdog");

  wd_config_word_a: assert property (watchdogResetReq |-> $past(fuseQ))
    else $error("watchdog reset without enable config_word");

  wd_clear_a: assert property (wdClear && assignWd |=>
    watchdogQ == 8'h0 && prescaleQ == 8'h0)
    else $error("watchdog clear left counts standing");

  ext_rise_a: assert property (extRiseSeen ##0 (assignWd && !zeroCheck
    && !wrAccess) |=> counterQ == $past(counterQ) + 8'h1)
    else $error("rising pin edge not counted");

  ext_only_a: assert property (optionQ[rcw_pkg::OPT_SOURCE_BIT]
    && !oscRise && !wrAccess |=> $stable(counterQ))
    else $error("counter moved without an oscillator sample");

  pre_count_a: assert property (!assignWd && srcTick && !zeroCheck
    && !wrAccess |=> prescaleQ == $past(prescaleQ) + 8'h1)
    else $error("prescaler missed a source tick");

  pre_gate_a: assert property (!assignWd && srcTick && !psFull
    && !wrAccess |=> $stable(counterQ))
    else $error("counter advanced before prescaler output");

  rate_mask_a: assert property (
    optionQ[rcw_pkg::OPT_RATE_LSB +: 3] == 3'h7
    |-> mask == (assignWd ? 8'h7f : 8'hff))
    else $error("top rate did not give full ratio");

  cnt_load_a: assert property (cntWrite |=>
    counterQ == $past(pwdata[7:0]))
    else $error("counter write did not load value");

  wd_count_a: assert property (wdTick && !wdClear |=>
    watchdogQ == $past(watchdogQ) + 8'h1)
    else $error("watchdog missed a timebase tick");

  wd_zero_a: assert property (wdClear |=>
    watchdogQ == 8'h0 && !wdTick)
    else $error("watchdog clear did not restart count");

  wd_pulse_a: assert property (watchdogResetReq |=>
    !watchdogResetReq)
    else $error("reset request longer than one cycle");

  roll_irq_a: assert property (statusQ[rcw_pkg::STAT_ROLLOVER_BIT]
    && irqEnableQ[rcw_pkg::STAT_ROLLOVER_BIT]
    && optionQ[rcw_pkg::OPT_ROLL_IE_BIT] |-> irq)
    else $error("enabled rollover did not raise interrupt");

  irq_off_a: assert property ((statusQ & irqEnableQ) == 2'h0
    |-> !irq)
    else $error("interrupt without enabled status");

endmodule // rcw_timer
`default_nettype wire

/* File: tb_rcw_timer.sv */
// self-checking bench for the counter, watchdog and prescaler block
`timescale 1ns/1ns
`default_nettype none
module tb_rcw_timer;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic config_word, wdReset, irq, oscPin, countPin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int failures = 0;
  int checks = 0;
  rcw_timer #(.WD_TICK_CYCLES(8)) dut_u (.clock(clock), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .counterPin(countPin), .oscillatorInputPin(oscPin),
    .watchdogEnableFuse(config_word), .watchdogResetReq(wdReset), .irq(irq));
  rcw_event_src src_u (.clock(clock), .oscPin(oscPin), .countPin(countPin));
  task automatic give_verdict;
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; entered and left between clock edges
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    while (!done) begin
      @(posedge clock);
      done = (pready === 1'b1);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
  endtask
  task automatic t_reset;
    apb(1'b0, rcw_pkg::OFS_OPTION, 32'h0);
    chk("option", 32'h0000000f, rdata);
    apb(1'b0, rcw_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk("irq enable", 32'h0, rdata);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask
  task automatic t_rate;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, rcw_pkg::OFS_OPTION, 32'(r));
      apb(1'b1, rcw_pkg::OFS_COUNTER, 32'h0);
      repeat (64) @(negedge clock);
      apb(1'b0, rcw_pkg::OFS_COUNTER, 32'h0);
      chk("prescaled count", 32'(64 >> (r + 1)), rdata);
    end
  endtask
  task automatic t_roll;
    int n;
    n = 0;
    apb(1'b1, rcw_pkg::OFS_IRQ_ENABLE, 32'h1);
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h80);
    apb(1'b1, rcw_pkg::OFS_COUNTER, 32'hfe);
    while (irq !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk("rollover time", 32'h1, {31'h0, n > 1 && n < 12});
    apb(1'b0, rcw_pkg::OFS_TIMER1_CTRL_B, 32'h0);
    chk("pending flag", 32'h80, rdata & 32'h80);
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h00);
    chk("irq gated", 32'h0, {31'h0, irq});
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h80);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, rcw_pkg::OFS_TIMER1_CTRL_B, 32'h0);
    apb(1'b1, rcw_pkg::OFS_IRQ_CLEAR, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, rcw_pkg::OFS_TIMER1_CTRL_B, 32'h0);
    chk("pending cleared", 32'h0, rdata & 32'h80);
  endtask
  task automatic t_ext;
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h28);
    apb(1'b1, rcw_pkg::OFS_COUNTER, 32'h0);
    src_u.pulses(5);
    apb(1'b0, rcw_pkg::OFS_COUNTER, 32'h0);
    chk("rising edges", 32'h5, rdata);
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h38);
    apb(1'b1, rcw_pkg::OFS_COUNTER, 32'h0);
    src_u.pulses(3);
    repeat (16) @(negedge clock);
    apb(1'b0, rcw_pkg::OFS_COUNTER, 32'h0);
    chk("falling edges", 32'h3, rdata);
  endtask
  // one counted tick is swallowed by the zero-check access cycle
  task automatic t_zero;
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h08);
    apb(1'b1, rcw_pkg::OFS_COUNTER, 32'h0);
    apb(1'b0, rcw_pkg::OFS_ZERO_CHECK, 32'h0);
    chk("zero-check read", 32'h1, rdata);
    apb(1'b0, rcw_pkg::OFS_COUNTER, 32'h0);
    chk("count after zero-check", 32'h3, rdata);
  endtask
  task automatic t_wdog;
    int n;
    n = 0;
    @(posedge clock);
    config_word <= 1'b1;
    apb(1'b1, rcw_pkg::OFS_IRQ_ENABLE, 32'h2);
    apb(1'b1, rcw_pkg::OFS_OPTION, 32'h08);
    apb(1'b1, rcw_pkg::OFS_COMMAND, 32'h1);
    repeat (1500) @(negedge clock);
    apb(1'b1, rcw_pkg::OFS_COMMAND, 32'h1);
    apb(1'b0, rcw_pkg::OFS_WATCHDOG, 32'h0);
    chk("cleared count", 32'h0, rdata);
    while (wdReset !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk("expiry time", 32'h1, {31'h0, n > 2000 && n < 2100});
    apb(1'b0, rcw_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("expired status", 32'h2, rdata & 32'h2);
    chk("wd irq", 32'h1, {31'h0, irq});
    apb(1'b1, rcw_pkg::OFS_IRQ_CLEAR, 32'h2);
    chk("wd irq cleared", 32'h0, {31'h0, irq});
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // whole run takes about 4100 cycles
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    config_word = 1'b0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    t_reset();
    t_rate();
    t_roll();
    t_ext();
    t_zero();
    t_wdog();
    give_verdict();
  end
endmodule // tb_rcw_timer
`default_nettype wire
